/* File: dv/scp_master.sv */
// Behavioural two-wire bus master that faces the serial control port
`timescale 1ns/1ps
module scp_master (
   input wire logic sda_i,
   output logic scl_o,
   output logic sda_oe_o
);
   // Quarter of a bit period; the bench stretches it for a slow master
   int quarter_ns;

   // Bus idle: clock stands high, data released to the pull-up
   initial begin
      scl_o = 1'b1;
      sda_oe_o = 1'b0;
      quarter_ns = 16;
   end

   // Start from idle, or a repeated start from a held low clock
   task automatic start();
      if (scl_o === 1'b0) begin
         #(quarter_ns);
         sda_oe_o = 1'b0;
         #(quarter_ns);
         scl_o = 1'b1;
         #(quarter_ns);
      end
      sda_oe_o = 1'b1;
      #(quarter_ns);
      scl_o = 1'b0;
   endtask : start

   // Stop: data rises while the clock is high
   task automatic stop();
      #(quarter_ns);
      sda_oe_o = 1'b1;
      #(quarter_ns);
      scl_o = 1'b1;
      #(quarter_ns);
      sda_oe_o = 1'b0;
      #(quarter_ns);
   endtask : stop

   // One bit; data moves only in the low phase, sampled mid high phase
   task automatic put_bit(input logic b, output logic seen);
      #(quarter_ns);
      sda_oe_o = ~b;
      #(quarter_ns);
      scl_o = 1'b1;
      #(quarter_ns);
      seen = sda_i;
      #(quarter_ns);
      scl_o = 1'b0;
   endtask : put_bit

   // Up to eight bits, most significant first; fewer bits cut a byte short
   task automatic xfer_byte(input logic [7:0] tx, input int nbits, output logic [7:0] rx);
      logic s;
      rx = 8'h00;
      for (int i = 7; i >= 8 - nbits; i--) begin
         put_bit(tx[i], s);
         rx[i] = s;
      end
   endtask : xfer_byte
endmodule : scp_master

/* File: dv/scp_top_tb.sv */
// Self-checking bench for the serial control port and its registers
`timescale 1ns/1ps
module scp_top_tb;
   import scp_pkg::*;
   logic clk_i = 1'b0;
   logic reset_n_i = 1'b0;
   logic [1:0] pins = 2'h0;
   logic sog = 1'b0;
   logic coast = 1'b0;
   logic scl, m_oe, sda_o, sda_oe, sda;
   logic out444, div2, abw, aen, ahold;
   logic [1:0] sbw, rate;
   logic [7:0] red, grn, blu, rx_dummy;
   logic [7:0] shadow [256];
   logic [7:0] wbuf [10];
   int bad_count = 0;
   int comparisons = 0;
   int cycles = 0;

   always #2.5 clk_i = ~clk_i;
   // Open-drain wire: low if either side pulls, else the pull-up wins
   assign sda = ~(m_oe | sda_oe);

   scp_master m (.sda_i(sda), .scl_o(scl), .sda_oe_o(m_oe));
   scp_top dut (
      .clk_i(clk_i), .reset_n_i(reset_n_i), .scl_i(scl), .sda_i(sda),
      .sda_o(sda_o), .sda_oe_o(sda_oe), .addr_select_pins_i(pins),
      .sync_green_input_i(sog), .coast_polarity_i(coast), .output_444_o(out444),
      .pll_extra_div2_o(div2), .sync_green_bw_o(sbw), .analog_bw_7mhz_o(abw),
      .red_target_o(red), .green_target_o(grn), .blue_target_o(blu),
      .auto_offset_en_o(aen), .auto_offset_hold_o(ahold), .auto_offset_rate_o(rate)
   );

   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : give_verdict

   // Cut a hung run short; even at the slowest master speed the whole run needs fewer cycles
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 60000) begin
         bad_count++;
         give_verdict();
      end
   end

   task automatic chk_val(input string what, input logic [7:0] exp, input logic [7:0] got);
      comparisons++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask : chk_val

   // Writable bits of each offset; everything else reads back 0 except the status bits
   function automatic logic [7:0] wmask(input logic [7:0] a);
      case (a)
         REG_OUT_FMT: return 8'h02;
         REG_PLL_FLT: return 8'hf0;
         REG_RED_TGT, REG_GRN_TGT, REG_BLU_TGT: return 8'hff;
         REG_AOFS_CTL: return 8'hc3;
         default: return 8'h00;
      endcase
   endfunction : wmask

   function automatic logic [7:0] exp_reg(input logic [7:0] a);
      if (a == REG_STATUS) return {6'h00, sog, coast};
      return shadow[a] & wmask(a);
   endfunction : exp_reg

   function automatic logic [6:0] my_addr();
      return {SLAVE_ADDR_HI, pins};
   endfunction : my_addr

   task automatic do_reset();
      @(posedge clk_i);
      reset_n_i <= 1'b0;
      repeat (8) @(posedge clk_i);
      reset_n_i <= 1'b1;
      foreach (shadow[i]) shadow[i] = 8'h00;
      shadow[REG_OUT_FMT] = 8'h02;
      shadow[REG_RED_TGT] = 8'h04;
      shadow[REG_GRN_TGT] = 8'h04;
      shadow[REG_BLU_TGT] = 8'h04;
      shadow[REG_AOFS_CTL] = 8'h02;
      // Bus must idle a few clocks before the first start
      repeat (20) @(posedge clk_i);
   endtask : do_reset

   task automatic check_outputs();
      chk_val("output_444", {7'h0, shadow[REG_OUT_FMT][1]}, {7'h0, out444});
      chk_val("pll_div2", {7'h0, shadow[REG_PLL_FLT][7]}, {7'h0, div2});
      chk_val("sog_bw", {6'h0, shadow[REG_PLL_FLT][6:5]}, {6'h0, sbw});
      chk_val("analog_bw", {7'h0, shadow[REG_PLL_FLT][4]}, {7'h0, abw});
      chk_val("red_target", shadow[REG_RED_TGT], red);
      chk_val("green_target", shadow[REG_GRN_TGT], grn);
      chk_val("blue_target", shadow[REG_BLU_TGT], blu);
      chk_val("aofs_en", {7'h0, shadow[REG_AOFS_CTL][7]}, {7'h0, aen});
      chk_val("aofs_hold", {7'h0, shadow[REG_AOFS_CTL][6]}, {7'h0, ahold});
      chk_val("aofs_rate", {6'h0, shadow[REG_AOFS_CTL][1:0]}, {6'h0, rate});
   endtask : check_outputs

   task automatic send_addr(input logic [6:0] dev, input logic rd, input logic exp_ack);
      logic s;
      @(negedge clk_i); // Master edges then never meet the sampling edge
      m.start();
      m.xfer_byte({dev, rd}, 8, rx_dummy);
      m.put_bit(1'b1, s);
      chk_val("addr ack", {7'h0, exp_ack}, {7'h0, ~s});
   endtask : send_addr

   task automatic put_byte(input logic [7:0] b);
      logic s;
      m.xfer_byte(b, 8, rx_dummy);
      m.put_bit(1'b1, s);
      chk_val("byte ack", 8'h00, {7'h0, s});
   endtask : put_byte

   task automatic write_regs(input logic [7:0] base, input int n);
      send_addr(my_addr(), 1'b0, 1'b1);
      put_byte(base);
      for (int i = 0; i < n; i++) begin
         put_byte(wbuf[i]);
         shadow[8'(base + i)] = wbuf[i];
      end
      m.stop();
      repeat (4) @(posedge clk_i);
      check_outputs();
   endtask : write_regs

   task automatic read_regs(input logic [7:0] base, input int n);
      logic [7:0] rx;
      logic s;
      send_addr(my_addr(), 1'b0, 1'b1);
      put_byte(base);
      send_addr(my_addr(), 1'b1, 1'b1);
      for (int i = 0; i < n; i++) begin
         m.xfer_byte(8'hff, 8, rx);
         chk_val("read data", exp_reg(8'(base + i)), rx);
         m.put_bit(i == n - 1, s);
      end
      chk_val("released at nack", 8'h01, {7'h0, s});
      m.stop();
   endtask : read_regs

   initial begin
      void'($urandom(22));
      do_reset();
      check_outputs();
      read_regs(REG_STATUS, 10);
      $display("test reset_values done");
      // Every pin setting: a neighbour's address and a foreign one are ignored
      for (int p = 0; p < 4; p++) begin
         @(posedge clk_i);
         pins <= 2'(p);
         repeat (4) @(posedge clk_i);
         send_addr({SLAVE_ADDR_HI, 2'(p + 1)}, 1'b0, 1'b0);
         m.stop();
         send_addr(my_addr() ^ 7'h40, 1'b1, 1'b0);
         m.stop();
         read_regs(REG_OUT_FMT, 1);
      end
      $display("test address_select done");
      // Random bursts over writable, read-only and unmapped offsets at varied master speed
      for (int r = 0; r < 6; r++) begin
         m.quarter_ns = 16 + 12 * ($urandom % 3);
         foreach (wbuf[i]) wbuf[i] = 8'($urandom);
         @(posedge clk_i);
         sog <= r[1];
         coast <= r[0];
         write_regs(8'(8'h14 + r % 4), 7);
         read_regs(REG_STATUS, 10);
      end
      read_regs(8'hfe, 3);
      $display("test random_bursts done");
      // A byte cut short by a stop, then one cut short by a repeated start
      send_addr(my_addr(), 1'b0, 1'b1);
      put_byte(REG_RED_TGT);
      m.xfer_byte(~shadow[REG_RED_TGT], 5, rx_dummy);
      m.stop();
      send_addr(my_addr(), 1'b0, 1'b1);
      put_byte(REG_BLU_TGT);
      m.xfer_byte(~shadow[REG_BLU_TGT], 3, rx_dummy);
      read_regs(REG_RED_TGT, 3);
      check_outputs();
      $display("test aborted_bytes done");
      // Reset in mid-run restores every default
      do_reset();
      check_outputs();
      read_regs(REG_RED_TGT, 5);
      chk_val("sda_o", 8'h00, {7'h0, sda_o});
      $display("test second_reset done");
      give_verdict();
   end
endmodule : scp_top_tb

/* File: src/scp_pkg.sv */
// Shared constants and types for the serial control port and its registers
package scp_pkg;
   // Register offsets
   localparam logic [7:0] REG_STATUS = 8'h14;
   localparam logic [7:0] REG_OUT_FMT = 8'h15;
   localparam logic [7:0] REG_PLL_FLT = 8'h16;
   localparam logic [7:0] REG_RED_TGT = 8'h19;
   localparam logic [7:0] REG_GRN_TGT = 8'h1a;
   localparam logic [7:0] REG_BLU_TGT = 8'h1b;
   localparam logic [7:0] REG_AOFS_CTL = 8'h1d;
   // Field positions
   localparam int STS_SOG_BIT = 1;
   localparam int STS_COAST_BIT = 0;
   localparam int FMT_444_BIT = 1;
   localparam int PLL_DIV2_BIT = 7;
   localparam int SOG_BW_HI = 6;
   localparam int SOG_BW_LO = 5;
   localparam int AIN_BW_BIT = 4;
   localparam int AOFS_EN_BIT = 7;
   localparam int AOFS_HOLD_BIT = 6;
   localparam int AOFS_RATE_HI = 1;
   localparam int AOFS_RATE_LO = 0;
   // Reset values
   localparam logic FMT_444_RST = 1'b1;
   localparam logic PLL_DIV2_RST = 1'b0;
   localparam logic [1:0] SOG_BW_RST = 2'h0;
   localparam logic AIN_BW_RST = 1'b0;
   localparam logic [7:0] TGT_RST = 8'h04;
   localparam logic AOFS_EN_RST = 1'b0;
   localparam logic AOFS_HOLD_RST = 1'b0;
   localparam logic [1:0] AOFS_RATE_RST = 2'h2;
   // Fixed upper part of the slave address, low two bits come from the pins
   localparam logic [4:0] SLAVE_ADDR_HI = 5'h13;
   // Bit counting on the serial bus
   localparam logic [3:0] BYTE_BITS = 4'h8;
   localparam logic [3:0] LAST_TX_BIT = 4'h7;
   // Serial port states, Gray coded along idle-addr-ack-rx / tx-mack
   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_ADDR = 3'h1,
      ST_ACK = 3'h3,
      ST_RX = 3'h2,
      ST_TX = 3'h6,
      ST_MACK = 3'h7
   } scp_state_t;
endpackage : scp_pkg

/* File: src/scp_regs.sv */
// Control and status register file behind the serial port
`timescale 1ns/1ps
module scp_regs (
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic wr_en_i,
   input wire logic [7:0] addr_i,
   input wire logic [7:0] wr_data_i,
   input wire logic sog_active_i,
   input wire logic coast_pol_i,
   output logic [7:0] rd_data_o,
   output logic output_444_o,
   output logic pll_extra_div2_o,
   output logic [1:0] sync_green_bw_o,
   output logic analog_bw_7mhz_o,
   output logic [7:0] red_target_o,
   output logic [7:0] green_target_o,
   output logic [7:0] blue_target_o,
   output logic auto_offset_en_o,
   output logic auto_offset_hold_o,
   output logic [1:0] auto_offset_rate_o
);
   import scp_pkg::*;

   // Output format select, 0 packs 4:2:2 onto 16 lines
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         output_444_o <= FMT_444_RST;
      end else if (wr_en_i && addr_i == REG_OUT_FMT) begin
         output_444_o <= wr_data_i[FMT_444_BIT];
      end
   end

   // PLL divider and input filter bandwidths
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         pll_extra_div2_o <= PLL_DIV2_RST;
         sync_green_bw_o <= SOG_BW_RST;
         analog_bw_7mhz_o <= AIN_BW_RST;
      end else if (wr_en_i && addr_i == REG_PLL_FLT) begin
         pll_extra_div2_o <= wr_data_i[PLL_DIV2_BIT];
         sync_green_bw_o <= wr_data_i[SOG_BW_HI:SOG_BW_LO];
         analog_bw_7mhz_o <= wr_data_i[AIN_BW_BIT];
      end
   end

   // Per-channel offset targets
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         red_target_o <= TGT_RST;
         green_target_o <= TGT_RST;
         blue_target_o <= TGT_RST;
      end else if (wr_en_i) begin
         if (addr_i == REG_RED_TGT) begin
            red_target_o <= wr_data_i;
         end
         if (addr_i == REG_GRN_TGT) begin
            green_target_o <= wr_data_i;
         end
         if (addr_i == REG_BLU_TGT) begin
            blue_target_o <= wr_data_i;
         end
      end
   end

   // Auto-offset control; rate code 11 is kept as written
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         auto_offset_en_o <= AOFS_EN_RST;
         auto_offset_hold_o <= AOFS_HOLD_RST;
         auto_offset_rate_o <= AOFS_RATE_RST;
      end else if (wr_en_i && addr_i == REG_AOFS_CTL) begin
         auto_offset_en_o <= wr_data_i[AOFS_EN_BIT];
         auto_offset_hold_o <= wr_data_i[AOFS_HOLD_BIT];
         auto_offset_rate_o <= wr_data_i[AOFS_RATE_HI:AOFS_RATE_LO];
      end
   end

   // Read mux, undefined bits and unmapped offsets read as zero
   always_comb begin
      rd_data_o = 8'h00;
      case (addr_i)
         REG_STATUS: begin
            rd_data_o[STS_SOG_BIT] = sog_active_i;
            rd_data_o[STS_COAST_BIT] = coast_pol_i;
         end
         REG_OUT_FMT: rd_data_o[FMT_444_BIT] = output_444_o;
         REG_PLL_FLT: begin
            rd_data_o[PLL_DIV2_BIT] = pll_extra_div2_o;
            rd_data_o[SOG_BW_HI:SOG_BW_LO] = sync_green_bw_o;
            rd_data_o[AIN_BW_BIT] = analog_bw_7mhz_o;
         end
         REG_RED_TGT: rd_data_o = red_target_o;
         REG_GRN_TGT: rd_data_o = green_target_o;
         REG_BLU_TGT: rd_data_o = blue_target_o;
         REG_AOFS_CTL: begin
            rd_data_o[AOFS_EN_BIT] = auto_offset_en_o;
            rd_data_o[AOFS_HOLD_BIT] = auto_offset_hold_o;
            rd_data_o[AOFS_RATE_HI:AOFS_RATE_LO] = auto_offset_rate_o;
         end
         default: rd_data_o = 8'h00;
      endcase
   end
endmodule : scp_regs

/* File: src/scp_sync.sv */
// Two-flop synchroniser for pins arriving from outside the clock domain
`timescale 1ns/1ps
module scp_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] RST_VAL = '0
) (
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic [WIDTH-1:0] d_i,
   output logic [WIDTH-1:0] q_o
);
   logic [WIDTH-1:0] meta;

   // First stage feeds only the second stage
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         meta <= RST_VAL;
         q_o <= RST_VAL;
      end else begin
         meta <= d_i;
         q_o <= meta;
      end
   end
endmodule : scp_sync

/* File: src/scp_top.sv */
// Two-wire serial slave port giving a bus master access to the control registers
//
// Contract
// - Status bit 1 reads 1 while sync-green input shows activity, else 0.
// - Status bit 0 reports detected coast polarity, 1 positive, 0 negative.
// - Output select bit 0 gives 4:2:2, 1 gives 4:4:4.
// - PLL register bit 7 adds an extra divide-by-2 in PLL feedback.
// - Two bits pick sync-green bandwidth: 300, 13, 13 or 6.5 MHz.
// - One bit picks colour input bandwidth: 0 is 300 MHz, 1 is 7 MHz.
// - Three per-channel offset target bytes, each resetting to 4.
// - Auto-offset control bit 7 enables auto-offset, resets to 0.
// - Auto-offset control bit 6 holds the offset output, resets to 0.
// - Auto-offset bits 1:0 set update rate, reset value 10.
// - Slave with 7-bit address, low part chosen by address-select pins.
// - SDA changes only while SCL low; SDA change with SCL high is start/stop.
// - Start is SDA falling while SCL high; begins a sequence.
// - Stop is SDA rising while SCL high; ends the sequence.
// - First byte holds seven address bits then direction, 1 read, 0 write.
// - Matching address is acked by pulling SDA low on ninth pulse.
// - Every byte travels most significant bit first.
// - A withheld write ack leaves SDA high; master then stops.
// - Missing master ack in a read means end of data; SDA released.
// - Byte after write address sets base register; later bytes increment it.
// - Reads start at the base address set earlier, incrementing per byte.
// - Repeated start without stop is accepted.
`timescale 1ns/1ps
module scp_top (
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_o,
   input wire logic [1:0] addr_select_pins_i,
   input wire logic sync_green_input_i,
   input wire logic coast_polarity_i,
   output logic output_444_o,
   output logic pll_extra_div2_o,
   output logic [1:0] sync_green_bw_o,
   output logic analog_bw_7mhz_o,
   output logic [7:0] red_target_o,
   output logic [7:0] green_target_o,
   output logic [7:0] blue_target_o,
   output logic auto_offset_en_o,
   output logic auto_offset_hold_o,
   output logic [1:0] auto_offset_rate_o
);
   import scp_pkg::*;

   // Address match on the top seven bits against the strapped address
   function automatic logic addr_match(input logic [7:0] b, input logic [1:0] sel);
      addr_match = (b[7:1] == {SLAVE_ADDR_HI, sel});
   endfunction : addr_match

   scp_state_t st;
   logic scl_q;
   logic sda_q;
   logic sog_q;
   logic coast_q;
   logic [1:0] sel_q;
   logic scl_d;
   logic sda_d;
   logic start_det;
   logic stop_det;
   logic scl_rise;
   logic scl_fall;
   logic byte_end;
   logic [3:0] bitcnt;
   logic [7:0] rx_sh;
   logic [7:0] tx_sh;
   logic [7:0] ptr;
   logic need_ptr;
   logic is_read;
   logic mack;
   logic wr_en;
   logic [7:0] rd_data;

   // Bus lines and status pins are asynchronous; idle bus levels are high
   scp_sync #(
      .WIDTH(6),
      .RST_VAL(6'h30)
   ) u_sync (
      .clk_i(clk_i),
      .reset_n_i(reset_n_i),
      .d_i({scl_i, sda_i, sync_green_input_i, coast_polarity_i, addr_select_pins_i}),
      .q_o({scl_q, sda_q, sog_q, coast_q, sel_q})
   );

   // Previous bus levels, read only from the synchronised copies
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         scl_d <= 1'b1;
         sda_d <= 1'b1;
      end else begin
         scl_d <= scl_q;
         sda_d <= sda_q;
      end
   end

   // Line events; SDA moving with SCL high marks start or stop
   assign start_det = scl_q && scl_d && sda_d && !sda_q;
   assign stop_det = scl_q && scl_d && !sda_d && sda_q;
   assign scl_rise = scl_q && !scl_d;
   assign scl_fall = !scl_q && scl_d;
   assign byte_end = scl_fall && (bitcnt == BYTE_BITS);
   assign wr_en = (st == ST_RX) && byte_end && !need_ptr;

   // Sequencer; start and stop override any byte in flight
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         st <= ST_IDLE;
         bitcnt <= 4'h0;
      end else if (start_det) begin
         st <= ST_ADDR;
         bitcnt <= 4'h0;
      end else if (stop_det) begin
         st <= ST_IDLE;
         bitcnt <= 4'h0;
      end else begin
         case (st)
            ST_ADDR: begin
               if (scl_rise) begin
                  bitcnt <= bitcnt + 4'h1;
               end else if (byte_end) begin
                  st <= addr_match(rx_sh, sel_q) ? ST_ACK : ST_IDLE;
               end
            end
            ST_ACK: begin
               if (scl_fall) begin
                  bitcnt <= 4'h0;
                  st <= is_read ? ST_TX : ST_RX;
               end
            end
            ST_RX: begin
               if (scl_rise) begin
                  bitcnt <= bitcnt + 4'h1;
               end else if (byte_end) begin
                  st <= ST_ACK;
               end
            end
            ST_TX: begin
               if (scl_fall) begin
                  if (bitcnt == LAST_TX_BIT) begin
                     st <= ST_MACK;
                  end else begin
                     bitcnt <= bitcnt + 4'h1;
                  end
               end
            end
            ST_MACK: begin
               if (scl_fall) begin
                  bitcnt <= 4'h0;
                  st <= mack ? ST_TX : ST_IDLE;
               end
            end
            default: begin
               st <= ST_IDLE;
               bitcnt <= 4'h0;
            end
         endcase
      end
   end

   // Receive shifter, first bit lands in the top position
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rx_sh <= 8'h00;
      end else if (scl_rise && (st == ST_ADDR || st == ST_RX)) begin
         rx_sh <= {rx_sh[6:0], sda_q};
      end
   end

   // Direction bit and master acknowledge capture
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         is_read <= 1'b0;
         mack <= 1'b0;
      end else begin
         if (st == ST_ADDR && byte_end) begin
            is_read <= rx_sh[0];
         end
         if (st == ST_MACK && scl_rise) begin
            mack <= !sda_q;
         end
      end
   end

   // Register pointer: set by first write byte, stepped after each byte
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         ptr <= 8'h00;
         need_ptr <= 1'b0;
      end else if (start_det || stop_det) begin
         need_ptr <= 1'b0;
      end else if (st == ST_ADDR && byte_end) begin
         need_ptr <= addr_match(rx_sh, sel_q) && !rx_sh[0];
      end else if (st == ST_RX && byte_end && need_ptr) begin
         ptr <= rx_sh;
         need_ptr <= 1'b0;
      end else if (wr_en) begin
         ptr <= ptr + 8'h01;
      end else if (st == ST_TX && scl_fall && bitcnt == LAST_TX_BIT) begin
         ptr <= ptr + 8'h01;
      end
   end

   // Transmit shifter loads from the pointer, shifts on each SCL fall
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         tx_sh <= 8'h00;
      end else if (scl_fall) begin
         if ((st == ST_ACK && is_read) || (st == ST_MACK && mack)) begin
            tx_sh <= rd_data;
         end else if (st == ST_TX) begin
            tx_sh <= {tx_sh[6:0], 1'b0};
         end
      end
   end

   // SDA drive: open drain, pulled low only for ack or a zero data bit.
   // Changes other than the release at start or stop follow a detected SCL fall, so SCL is already low.
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         sda_oe_o <= 1'b0;
      end else if (start_det || stop_det) begin
         sda_oe_o <= 1'b0;
      end else if (st == ST_ADDR && byte_end) begin
         sda_oe_o <= addr_match(rx_sh, sel_q);
      end else if (st == ST_RX && byte_end) begin
         sda_oe_o <= 1'b1;
      end else if (scl_fall) begin
         case (st)
            ST_ACK: sda_oe_o <= is_read && !rd_data[7];
            ST_TX: sda_oe_o <= (bitcnt != LAST_TX_BIT) && !tx_sh[6];
            ST_MACK: sda_oe_o <= mack && !rd_data[7];
            default: sda_oe_o <= sda_oe_o;
         endcase
      end
   end

   // Level driven while enabled is always low
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         sda_o <= 1'b0;
      end else begin
         sda_o <= 1'b0;
      end
   end

   // Register file; its control outputs are flops and leave the block directly, read data is combinational
   scp_regs u_regs (
      .clk_i(clk_i),
      .reset_n_i(reset_n_i),
      .wr_en_i(wr_en),
      .addr_i(ptr),
      .wr_data_i(rx_sh),
      .sog_active_i(sog_q),
      .coast_pol_i(coast_q),
      .rd_data_o(rd_data),
      .output_444_o(output_444_o),
      .pll_extra_div2_o(pll_extra_div2_o),
      .sync_green_bw_o(sync_green_bw_o),
      .analog_bw_7mhz_o(analog_bw_7mhz_o),
      .red_target_o(red_target_o),
      .green_target_o(green_target_o),
      .blue_target_o(blue_target_o),
      .auto_offset_en_o(auto_offset_en_o),
      .auto_offset_hold_o(auto_offset_hold_o),
      .auto_offset_rate_o(auto_offset_rate_o)
   );

   // Checks on the sequencer and the SDA drive
   chk_start_restart: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      start_det |=> (st == ST_ADDR) && (bitcnt == 4'h0) && !sda_oe_o)
      else $error("start did not restart address phase");

   chk_stop_to_idle: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      stop_det |=> (st == ST_IDLE) && !sda_oe_o)
      else $error("stop did not end the sequence");

   chk_ack_on_match: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (st == ST_ADDR && byte_end && !start_det && !stop_det)
      |=> (sda_oe_o == addr_match($past(rx_sh), sel_q)) && (st == ST_ACK) == sda_oe_o)
      else $error("address ack does not follow match");

   chk_sda_scl_low: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      ($changed(sda_oe_o) && !$past(start_det) && !$past(stop_det)) |-> !scl_d)
      else $error("SDA drive changed while SCL high");

   chk_tx_msb_first: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (st == ST_TX) |-> (sda_oe_o == !tx_sh[7]))
      else $error("transmitted bit is not the top of the shifter");

   chk_write_step: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      wr_en |=> (ptr == $past(ptr) + 8'h01))
      else $error("pointer did not step after a write");

   chk_read_load: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (st == ST_ACK && scl_fall && is_read && !start_det && !stop_det)
      |=> (st == ST_TX) && (tx_sh == $past(rd_data)))
      else $error("read did not load data at the pointer");

   chk_nack_release: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (st == ST_MACK && scl_fall && !mack && !start_det && !stop_det)
      |=> ((st == ST_IDLE) && !sda_oe_o) [*2])
      else $error("missing master ack did not release SDA");

   // Shifter takes the synchronised SDA level at each SCL rise in ST_ADDR or ST_RX, first bit ends on top
   chk_rx_shift_msb: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (scl_rise && (st == ST_ADDR || st == ST_RX))
      |=> (rx_sh == {$past(rx_sh[6:0]), $past(sda_q)}))
      else $error("receive shifter did not take SDA at the bottom");

   chk_dir_capture: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (st == ST_ADDR && byte_end) |=> (is_read == $past(rx_sh[0])))
      else $error("direction bit not taken from the eighth address bit");

   chk_ptr_load: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (st == ST_RX && byte_end && need_ptr) |=> (ptr == $past(rx_sh)) && !need_ptr)
      else $error("first write byte did not set the pointer");

   // A foreign address or an ended sequence must leave the wire to the pull-up
   chk_idle_released: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (st == ST_IDLE) |-> !sda_oe_o)
      else $error("SDA pulled low while the port is idle");

   cov_write: cover property (@(posedge clk_i) disable iff (!reset_n_i) wr_en);
   cov_read_burst: cover property (@(posedge clk_i) disable iff (!reset_n_i)
      st == ST_MACK && scl_fall && mack);
   cov_addr_nack: cover property (@(posedge clk_i) disable iff (!reset_n_i)
      st == ST_ADDR && byte_end && !addr_match(rx_sh, sel_q));
   cov_rep_start: cover property (@(posedge clk_i) disable iff (!reset_n_i)
      start_det && st != ST_IDLE);
   cov_cut_byte: cover property (@(posedge clk_i) disable iff (!reset_n_i)
      stop_det && st == ST_RX && bitcnt != 4'h0);
endmodule : scp_top
